// ### logic/psf_pkg.sv
/*
  Constants for the script flow-control block: instruction fields, opcodes,
  register offsets and field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 32.768 kHz script tick derived from it.
*/
// Summary of operation
// [R01] A jump continues fetching at its destination field, optionally repeating a sequence.
// [R02] Repeat tally zero branches every time until the host aborts the script.
// [R03] Tally 1 to 63 gives tally minus one repetitions, then falls through.
// [R04] Destinations 0 to 59 are valid; above 59 the jump does no looping.
// [R05] Host must never nest one counted loop inside another.
// [R06] Termination stops the script and asserts the active-low interrupt.
// [R07] Termination with release bit set disables the output, pin goes high impedance.
// [R08] Termination with release bit clear keeps driving the last duty cycle.
// [R09] Halting a channel stalled in a trigger wait raises no interrupt.
// [R10] A send-only synchronisation takes exactly sixteen script clock cycles.
// [R11] A waiting synchronisation takes at least sixteen script clock cycles.
// [R12] A waiting synchronisation stalls until all selected triggers pend, then clears them.
// [R13] A sent trigger stays latched at the receiver until its wait consumes it.
// [R14] Wait mask bits 0, 1, 2 select channels 0, 1, 2 as sources.
// [R15] Send mask bits 0, 1, 2 post triggers to channels 0, 1, 2.
// [R16] Jump: bits 15..13 are 101, tally 12..7, bit 6 zero, destination 5..0.
// [R17] Termination: bits 15..12 are 1100, release flag bit 11, rest zero.
// [R18] Synchronisation: bits 15..13 set, wait 12..7, send 6..1, bit 0 zero.
// [R19] Every script instruction is one fixed 16-bit word.
// [R20] Each channel keeps its own loop counter, reloaded after falling through.
// [R21] Pending triggers are stored per ordered sender and receiver pair.
package psf_pkg;

  localparam int NUM_CH   = 3;
  localparam int ADDR_W   = 6;
  localparam int WORD_W   = 16;
  localparam int SCR_DEPTH = 64;

  // Instruction fields
  localparam int OP_HI        = 15;
  localparam int JUMP_OP_LO   = 13;
  localparam int END_OP_LO    = 12;
  localparam int END_REL_BIT  = 11;
  localparam int TALLY_LSB    = 7;
  localparam int JUMP_ZERO_BIT = 6;
  localparam int DEST_LSB     = 0;
  localparam int WAIT_LSB     = 7;
  localparam int POST_LSB     = 1;
  localparam int SYNC_ZERO_BIT = 0;

  localparam logic [2:0]  OP_JUMP        = 3'h5;
  localparam logic [3:0]  OP_END         = 4'hC;
  localparam logic [2:0]  OP_SYNC        = 3'h7;
  localparam logic [5:0]  JUMP_DEST_MAX  = 6'h3B;
  localparam logic [5:0]  TALLY_ONE      = 6'h01;
  localparam logic [10:0] END_ZERO_FIELD = 11'h000;

  // Timing
  localparam int SYS_CLK_HZ     = 100000000;
  localparam int SCRIPT_CLK_HZ  = 32768;
  localparam int SCRIPT_TICK_CYC = SYS_CLK_HZ / SCRIPT_CLK_HZ;
  localparam logic [4:0] SYNC_MIN_TICKS = 5'h10;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_START  = 8'h08;
  localparam logic [7:0] REG_SCRIPT = 8'h0C;
  localparam logic [7:0] REG_TRIG   = 8'h10;

  // Field positions
  localparam int CTRL_START_LSB   = 0;
  localparam int CTRL_STOP_LSB    = 4;
  localparam int STAT_RUN_LSB     = 0;
  localparam int STAT_DONE_LSB    = 8;
  localparam int STAT_WAIT_LSB    = 16;
  localparam int START_STRIDE     = 8;
  localparam int SCR_ADDR_LSB     = 16;
  localparam int SCR_CH_LSB       = 24;
  localparam int TRIG_PEND_LSB    = 0;
  localparam int TRIG_OE_LSB      = 16;

  // Reset values
  localparam logic [23:0] START_RESET = 24'h000000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_EXT,
    ST_SYNC
  } psf_state_e;

endpackage

// ### logic/psf_script_mem.sv
/*
  Script command file of one channel: fixed 16-bit words, one write port and
  one read port whose data come out of a register and hold between reads.
  Assumes the writer and reader share clk_sys.
*/
`timescale 1ns/1ps
module psf_script_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ### logic/psf_trig_matrix.sv
/*
  Pending-trigger store, one flag per ordered sender and receiver pair.
  Index of a flag is receiver * N + sender. Posting wins over clearing.
  Assumes post and clear are one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
module psf_trig_matrix #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst,
  // Events
  input  wire logic [N*N-1:0] post,
  input  wire logic [N*N-1:0] clear,
  // State
  output logic      [N*N-1:0] pend
);

  for (genvar k = 0; k < N * N; k++) begin : g_flag
    // [R13] latched until consumed
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pend[k] <= 1'b0;
      end else if (post[k]) begin
        pend[k] <= 1'b1;
      end else if (clear[k]) begin
        pend[k] <= 1'b0;
      end
    end
  end

endmodule

// ### logic/psf_flow_ctrl.sv
/*
  Flow-control part of a three-channel PWM script engine with an AHB-Lite
  register slave. Each channel fetches 16-bit words from its script file,
  executes jump, termination and synchronisation itself, and hands every
  other word to the ramp/duty logic outside over ext_req / ext_done.
  Assumes a single clk_sys domain; ext_done is a one-cycle pulse.
*/
`timescale 1ns/1ps
module psf_flow_ctrl import psf_pkg::*; #(
  parameter int TICK_CYCLES = SCRIPT_TICK_CYC
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic      [31:0]                hrdata,
  // Ramp and duty logic
  output logic      [NUM_CH-1:0]          ext_req,
  output logic      [NUM_CH*WORD_W-1:0]   ext_cmd,
  input  wire logic [NUM_CH-1:0]          ext_done,
  // Channel outputs
  output logic      [NUM_CH-1:0]          pwm_oe,
  output logic      [NUM_CH-1:0]          script_run,
  output logic                            irq_n
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NN = NUM_CH * NUM_CH;

  // Bus address phase capture
  logic        ap_wr;
  logic [7:0]  ap_addr;
  logic [23:0] start_reg;
  logic [NUM_CH-1:0] done;
  logic [TW-1:0] tick_cnt;
  logic          tick;

  wire addr_ok = hsel && htrans[1] && hready;
  wire ctrl_wr   = ap_wr && (ap_addr == REG_CTRL);
  wire status_wr = ap_wr && (ap_addr == REG_STATUS);
  wire start_wr  = ap_wr && (ap_addr == REG_START);
  wire script_wr = ap_wr && (ap_addr == REG_SCRIPT);

  wire [NUM_CH-1:0] run_vec;
  wire [NUM_CH-1:0] wait_vec;
  wire [NUM_CH-1:0] oe_vec;
  wire [NUM_CH-1:0] done_set;
  wire [NN-1:0]     post_vec;
  wire [NN-1:0]     clear_vec;
  wire [NN-1:0]     pend_vec;

  wire [31:0] rd_status = {13'h0000, wait_vec, 5'h00, done, 5'h00, run_vec};
  wire [31:0] rd_trig   = {13'h0000, oe_vec, 7'h00, pend_vec};
  wire [31:0] rd_word   =
    (haddr[7:0] == REG_CTRL)   ? {29'h00000000, run_vec} :
    (haddr[7:0] == REG_STATUS) ? rd_status :
    (haddr[7:0] == REG_START)  ? {8'h00, start_reg} :
    (haddr[7:0] == REG_TRIG)   ? rd_trig :
    32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      ap_wr <= addr_ok && hwrite;
      if (addr_ok) begin
        ap_addr <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_reg <= START_RESET;
    end else if (start_wr) begin
      start_reg <= hwdata[23:0];
    end
  end

  // [R06] Termination raises the interrupt; set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done <= '0;
    end else begin
      done <= done_set | (done & ~(status_wr ? hwdata[STAT_DONE_LSB +: NUM_CH] : '0));
    end
  end

  assign irq_n = ~|done;

  // Script clock tick, one cycle per 32.768 kHz period
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
    end
  end

  // [R21] Pair-wise trigger store
  psf_trig_matrix #(
    .N (NUM_CH)
  ) u_trig (
    .clk_sys (clk_sys),
    .rst     (rst),
    .post    (post_vec),
    .clear   (clear_vec),
    .pend    (pend_vec)
  );

  assign pwm_oe     = oe_vec;
  assign script_run = run_vec;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    psf_state_e        state;
    psf_state_e        next_state;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] loop_cnt;
    logic [ADDR_W-1:0] next_loop_cnt;
    logic              loop_act;
    logic              next_loop_act;
    logic              oe;
    logic              next_oe;
    logic [4:0]        hold;
    logic [4:0]        next_hold;
    logic [WORD_W-1:0] instr;

    wire start_i = ctrl_wr && hwdata[CTRL_START_LSB + i];
    wire stop_i  = ctrl_wr && hwdata[CTRL_STOP_LSB + i];
    wire exec    = (state == ST_EXEC);
    wire mem_we  = script_wr && (hwdata[SCR_CH_LSB +: 2] == 2'(i));

    // [R19] One fixed word per instruction
    psf_script_mem #(
      .W     (WORD_W),
      .DEPTH (SCR_DEPTH),
      .AW    (ADDR_W)
    ) u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .we      (mem_we),
      .waddr   (hwdata[SCR_ADDR_LSB +: ADDR_W]),
      .wdata   (hwdata[WORD_W-1:0]),
      .re      (state == ST_FETCH),
      .raddr   (pc),
      .rdata   (instr)
    );

    // [R16] Jump decode
    wire is_jump = (instr[OP_HI:JUMP_OP_LO] == OP_JUMP) && !instr[JUMP_ZERO_BIT];
    // [R17] Termination decode
    wire is_end = (instr[OP_HI:END_OP_LO] == OP_END) && (instr[10:0] == END_ZERO_FIELD);
    // [R18] Synchronisation decode
    wire is_sync = (instr[OP_HI:JUMP_OP_LO] == OP_SYNC) && !instr[SYNC_ZERO_BIT];

    wire [5:0] tally = instr[TALLY_LSB +: 6];
    wire [5:0] dest  = instr[DEST_LSB +: 6];
    // [R14] Wait sources, low three bits
    wire [NUM_CH-1:0] wait_sel = instr[WAIT_LSB +: NUM_CH];
    wire [NUM_CH-1:0] my_pend  = pend_vec[i*NUM_CH +: NUM_CH];

    // [R20] Remaining repetitions of this channel
    wire [5:0] rem = loop_act ? loop_cnt : tally - TALLY_ONE;
    // [R04] Out-of-range destination does not loop
    wire dest_ok = (dest <= JUMP_DEST_MAX);
    // [R02] [R03] Branch when endless or repetitions left
    wire take_jump = dest_ok && ((tally == 6'h00) || (rem != 6'h00));

    // [R12] All selected sources pending and hold time over
    wire sync_ok = (state == ST_SYNC) && (hold == 5'h00) && (&(my_pend | ~wait_sel));

    assign clear_vec[i*NUM_CH +: NUM_CH] = sync_ok ? wait_sel : '0;

    // [R15] Post to each receiver r from this sender
    for (genvar r = 0; r < NUM_CH; r++) begin : g_post
      assign post_vec[r*NUM_CH + i] = exec && is_sync && instr[POST_LSB + r];
    end

    assign run_vec[i]  = (state != ST_IDLE);
    assign wait_vec[i] = (state == ST_SYNC);
    assign oe_vec[i]   = oe;
    assign ext_req[i]  = (state == ST_EXT);
    assign ext_cmd[i*WORD_W +: WORD_W] = instr;
    // [R09] No interrupt when halted during a trigger wait
    assign done_set[i] = (exec && is_end && !stop_i && !start_i) ||
                         (stop_i && (state != ST_IDLE) && (state != ST_SYNC));

    always_comb begin
      next_state    = state;
      next_pc       = pc;
      next_loop_cnt = loop_cnt;
      next_loop_act = loop_act;
      next_oe       = oe;
      next_hold     = hold;
      case (state)
        ST_FETCH: begin
          next_state = ST_EXEC;
        end
        ST_EXEC: begin
          if (is_jump) begin
            next_state = ST_FETCH;
            // [R01] Continue at destination
            if (take_jump) begin
              next_pc = dest;
              if (tally != 6'h00) begin
                next_loop_act = 1'b1;
                next_loop_cnt = rem - TALLY_ONE;
              end
            end else begin
              next_pc = pc + 6'h01;
              if (dest_ok) begin
                next_loop_act = 1'b0;
              end
            end
          end else if (is_end) begin
            // [R06] Stop the script
            next_state = ST_IDLE;
            // [R07] [R08] Release or keep the output
            if (instr[END_REL_BIT]) begin
              next_oe = 1'b0;
            end
          end else if (is_sync) begin
            // [R10] [R11] Sixteen tick minimum
            next_hold  = SYNC_MIN_TICKS;
            next_state = ST_SYNC;
          end else begin
            next_state = ST_EXT;
          end
        end
        ST_EXT: begin
          if (ext_done[i]) begin
            next_pc    = pc + 6'h01;
            next_state = ST_FETCH;
          end
        end
        ST_SYNC: begin
          if (tick && (hold != 5'h00)) begin
            next_hold = hold - 5'h01;
          end
          if (sync_ok) begin
            next_pc    = pc + 6'h01;
            next_state = ST_FETCH;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      // [R02] Host abort ends any loop
      if (stop_i) begin
        next_state = ST_IDLE;
      end
      if (start_i) begin
        next_state    = ST_FETCH;
        next_pc       = start_reg[i*START_STRIDE +: ADDR_W];
        next_loop_act = 1'b0;
        next_loop_cnt = 6'h00;
        next_oe       = 1'b1;
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        state    <= ST_IDLE;
        pc       <= 6'h00;
        loop_cnt <= 6'h00;
        loop_act <= 1'b0;
        oe       <= 1'b0;
        hold     <= 5'h00;
      end else begin
        state    <= next_state;
        pc       <= next_pc;
        loop_cnt <= next_loop_cnt;
        loop_act <= next_loop_act;
        oe       <= next_oe;
        hold     <= next_hold;
      end
    end
  end

endmodule

// ### bench/psf_flow_ctrl_monitor.sv
/*
  Port checker for psf_flow_ctrl, bound into every instance.
  Assumes one clk_sys domain and an active-high asynchronous rst.
*/
`timescale 1ns/1ps
module psf_flow_ctrl_monitor import psf_pkg::*; (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  // Observed ports
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [NUM_CH-1:0]          ext_req,
  input wire logic [NUM_CH*WORD_W-1:0]   ext_cmd,
  input wire logic [NUM_CH-1:0]          ext_done,
  input wire logic [NUM_CH-1:0]          pwm_oe,
  input wire logic [NUM_CH-1:0]          script_run,
  input wire logic                       irq_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");

  property p_req_run;
    (ext_req & ~script_run) == 3'h0;
  endproperty
  a_req_run: assert property (p_req_run) else $error("ext request from idle channel");

  property p_req_hold;
    ext_req[0] && !ext_done[0] |=> ext_req[0] || !script_run[0];
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("ext request dropped early");

  property p_cmd_stable;
    ext_req[0] && $past(ext_req[0]) |-> $stable(ext_cmd[15:0]);
  endproperty
  a_cmd_stable: assert property (p_cmd_stable) else $error("ext word moved");

  property p_req_release;
    ext_req[0] && ext_done[0] |=> !ext_req[0];
  endproperty
  a_req_release: assert property (p_req_release) else $error("ext request held after done");

  property p_irq_cause;
    $fell(irq_n) |-> |($past(script_run) & ~script_run);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without stop");

  property p_oe_off;
    $fell(pwm_oe[0]) |-> !script_run[0];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output released while running");

  property p_oe_start;
    $rose(script_run[0]) |-> pwm_oe[0];
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("started without output enable");
endmodule

bind psf_flow_ctrl psf_flow_ctrl_monitor i_psf_flow_ctrl_monitor (
  .clk_sys    (clk_sys),
  .rst        (rst),
  .hreadyout  (hreadyout),
  .hresp      (hresp),
  .ext_req    (ext_req),
  .ext_cmd    (ext_cmd),
  .ext_done   (ext_done),
  .pwm_oe     (pwm_oe),
  .script_run (script_run),
  .irq_n      (irq_n)
);

// ### bench/psf_ramp_model.sv
/*
  Ramp/duty responder: answers each ext_req with a one-cycle ext_done after
  dly extra cycles, and counts channel 0 commands.
  Assumes ext_req holds until ext_done is sampled.
*/
`timescale 1ns/1ps
module psf_ramp_model import psf_pkg::*; (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Handshake
  input wire logic [NUM_CH-1:0] ext_req,
  input wire logic [3:0]        dly,
  output logic     [NUM_CH-1:0] ext_done,
  output logic     [7:0]        cnt0
);
  logic [3:0] wait_cyc [NUM_CH];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_done <= '0;
      cnt0 <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) wait_cyc[i] <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ext_done[i] || !ext_req[i]) begin
          ext_done[i] <= 1'b0;
          wait_cyc[i] <= 4'h0;
        end else if (wait_cyc[i] == dly) begin
          ext_done[i] <= 1'b1;
          if (i == 0) cnt0 <= cnt0 + 8'h01;
        end else begin
          wait_cyc[i] <= wait_cyc[i] + 4'h1;
        end
      end
    end
  end
endmodule

// ### bench/psf_flow_ctrl_test.sv
/*
  Self-checking bench for psf_flow_ctrl: AHB-Lite tasks load and start
  scripts, and each test compares status, the loop tests also counts, the sync test timing.
  Assumes a short script tick of TK cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module psf_flow_ctrl_test import psf_pkg::*;;
  localparam int TK = 4;
  logic                          clk_sys;
  logic                          rst;
  logic                          hsel;
  logic [31:0]                   haddr;
  logic [1:0]                    htrans;
  logic                          hwrite;
  logic [2:0]                    hsize;
  logic [31:0]                   hwdata;
  logic [3:0]                    dly;
  logic [31:0]                   q;
  logic [7:0]                    c_base;
  wire logic                     hreadyout;
  wire logic                     hresp;
  wire logic [31:0]              hrdata;
  wire logic [NUM_CH-1:0]        ext_req;
  wire logic [NUM_CH*WORD_W-1:0] ext_cmd;
  wire logic [NUM_CH-1:0]        ext_done;
  wire logic [NUM_CH-1:0]        pwm_oe;
  wire logic [NUM_CH-1:0]        script_run;
  wire logic                     irq_n;
  wire logic [7:0]               cnt0;
  int                            n;
  int                            cyc;
  int                            mismatches;
  int                            samples_checked;

  psf_flow_ctrl #(.TICK_CYCLES(TK)) i_psf_flow_ctrl (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_req(ext_req), .ext_cmd(ext_cmd), .ext_done(ext_done), .pwm_oe(pwm_oe),
    .script_run(script_run), .irq_n(irq_n));
  psf_ramp_model i_psf_ramp_model (
    .clk_sys(clk_sys), .rst(rst), .ext_req(ext_req), .dly(dly), .ext_done(ext_done), .cnt0(cnt0));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic load(input logic [1:0] ch, input logic [5:0] ad, input logic [15:0] wd);
    bus(1'b1, REG_SCRIPT, {6'h00, ch, 2'h0, ad, wd});
  endtask

  task automatic run(input int ch);
    bus(1'b1, REG_CTRL, 32'h1 << ch);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (script_run[ch] !== 1'b0 && n < 3000);
    `CHK("run ended", 1'b0, script_run[ch])
  endtask

  task automatic endt(input string s);
    bus(1'b1, REG_STATUS, 32'h00000700);
    @(posedge clk_sys);
    $display("test %s done", s);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    dly = 4'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("pwm_oe", 3'h0, pwm_oe)
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, REG_START, 32'h0);
    `CHK("start", {8'h00, START_RESET}, q)
    bus(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, q)
    endt("reset");
    load(2'h0, 6'h00, 16'h4000);
    load(2'h0, 6'h01, 16'h4000);
    load(2'h0, 6'h02, 16'hA181);
    load(2'h0, 6'h03, 16'hC000);
    c_base = cnt0;
    run(0);
    `CHK("loop count", c_base + 8'h04, cnt0)
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("oe kept", 1'b1, pwm_oe[0])
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("done", 3'h1, q[10:8])
    bus(1'b1, REG_STATUS, 32'h00000700);
    // Second counted loop after the first has fallen through
    load(2'h0, 6'h03, 16'h4000);
    load(2'h0, 6'h04, 16'hA183);
    load(2'h0, 6'h05, 16'hC000);
    c_base = cnt0;
    run(0);
    `CHK("reload", c_base + 8'h07, cnt0)
    endt("counted loop");
    `CHK("irq clear", 1'b1, irq_n)
    load(2'h0, 6'h04, 16'hE001);
    load(2'h0, 6'h05, 16'hA084);
    load(2'h0, 6'h06, 16'hA2BC);
    load(2'h0, 6'h07, 16'hC800);
    bus(1'b1, REG_START, 32'h00000004);
    c_base = cnt0;
    run(0);
    `CHK("tally one", c_base + 8'h01, cnt0)
    `CHK("oe off", 1'b0, pwm_oe[0])
    `CHK("irq_n", 1'b0, irq_n)
    endt("fall through");
    dly <= 4'h9;
    load(2'h0, 6'h08, 16'h4000);
    load(2'h0, 6'h09, 16'hA008);
    bus(1'b1, REG_START, 32'h00000008);
    c_base = cnt0;
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (200) @(posedge clk_sys);
    `CHK("endless", 1'b1, script_run[0])
    `CHK("repeats", 1'b1, (cnt0 - c_base) > 8'h05)
    do @(posedge clk_sys); while (ext_req[0] !== 1'b1);
    `CHK("ext word", 16'h4000, ext_cmd[15:0])
    bus(1'b1, REG_CTRL, 32'h10);
    @(posedge clk_sys);
    `CHK("aborted", 1'b0, script_run[0])
    endt("endless loop");
    dly <= 4'h0;
    load(2'h1, 6'h00, 16'hE00A);
    load(2'h1, 6'h01, 16'hC000);
    load(2'h0, 6'h0A, 16'hE100);
    load(2'h0, 6'h0B, 16'hC000);
    load(2'h2, 6'h00, 16'hE080);
    load(2'h2, 6'h01, 16'hC000);
    bus(1'b1, REG_START, 32'h0000000A);
    run(1);
    `CHK("send len", 1'b1, n >= 16 * TK && n <= 17 * TK + 6)
    bus(1'b0, REG_TRIG, 32'h0);
    `CHK("posted", 9'h082, q[8:0])
    run(0);
    `CHK("wait len", 1'b1, n >= 16 * TK && n <= 17 * TK + 6)
    bus(1'b0, REG_TRIG, 32'h0);
    `CHK("consumed", 9'h080, q[8:0])
    endt("sync");
    bus(1'b1, REG_CTRL, 32'h4);
    repeat (100) @(posedge clk_sys);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("stalled", 3'h4, q[18:16])
    bus(1'b1, REG_CTRL, 32'h40);
    @(posedge clk_sys);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("no done", 3'h0, q[10:8])
    `CHK("irq_n", 1'b1, irq_n)
    bus(1'b0, REG_TRIG, 32'h0);
    `CHK("kept", 9'h080, q[8:0])
    endt("halted wait");
    close_out();
  end
endmodule
